// ==== common/mtm_pkg.sv ====
// Package with the register map, field layout and reset values of the timer.
package mtm_pkg;

    // Byte offsets of the four registers on the register bus.
    localparam logic [11:0] ADDR_STATUS_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CLOCK_CFG = 12'h004;
    localparam logic [11:0] ADDR_COUNT = 12'h008;
    localparam logic [11:0] ADDR_LIMIT = 12'h00C;

    // Status and control field positions.
    localparam int SC_OVF_BIT = 7;
    localparam int SC_IRQ_EN_BIT = 6;
    localparam int SC_CNT_RST_BIT = 5;
    localparam int SC_HALT_BIT = 4;

    // Clock configuration field positions.
    localparam int CLK_SRC_LSB = 4;
    localparam int CLK_PS_LSB = 0;

    // Count source encodings.
    localparam logic [1:0] SRC_BUS = 2'h0;
    localparam logic [1:0] SRC_FIXED = 2'h1;
    localparam logic [1:0] SRC_PIN_FALL = 2'h2;
    localparam logic [1:0] SRC_PIN_RISE = 2'h3;

    // Highest prescale code with its own ratio; larger codes divide by 256.
    localparam logic [3:0] PS_MAX_CODE = 4'h8;

    // Reset values.
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [1:0] RST_SRC = SRC_BUS;
    localparam logic [3:0] RST_PS = 4'h0;
    localparam logic RST_HALT = 1'b1;
    localparam logic RST_IRQ_EN = 1'b0;

    // Count value at which a free-running counter wraps.
    localparam logic [7:0] FREE_RUN_TOP = 8'hFF;

endpackage : mtm_pkg

// ==== core/mtm_edge_sync.sv ====
// Pin synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
`default_nettype none
module mtm_edge_sync (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Asynchronous pin and edge pulses.
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Two flops for the crossing, a third holds the previous level.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // One pulse per edge, read only from the second and third flops.
    assign rise_o = sync_reg & ~last_reg;
    assign fall_o = ~sync_reg & last_reg;

endmodule : mtm_edge_sync
`default_nettype wire

// ==== core/mtm_prescaler.sv ====
// Power-of-two prescaler that thins a tick stream.
`timescale 1ns/1ps
`default_nettype none
module mtm_prescaler
    import mtm_pkg::*;
#(
    parameter int DIV_W = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Input ticks, ratio code and thinned ticks.
    input wire logic tick_i,
    input wire logic [3:0] sel_i,
    output logic tick_o
);

    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] mask;
    logic [3:0] code;

    // The divider only moves on source ticks, so any source can be scaled.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= '0;
        end else if (tick_i) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // Codes above the top code fall back to the largest ratio.
    always_comb begin
        code = (sel_i > PS_MAX_CODE) ? PS_MAX_CODE : sel_i;
        mask = DIV_W'((9'h001 << code) - 9'h001);
    end

    // A tick passes when all low bits selected by the ratio are ones.
    assign tick_o = tick_i & ((div_reg & mask) == mask);

endmodule : mtm_prescaler
`default_nettype wire

// ==== core/mtm_timer.sv ====
// Modulo timer top with its APB register slave.
`timescale 1ns/1ps
`default_nettype none
module mtm_timer
    import mtm_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // APB slave port.
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Count sources from outside the clock domain.
    input wire logic fixed_freq_clock_i,
    input wire logic ext_count_pin_i,
    // Overflow interrupt request.
    output logic irq_o
);

    logic rst_meta_reg;
    logic rst_n_reg;
    logic rst_n;

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_n_reg;

    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic irq_reg;
    logic [7:0] count_value_reg;
    logic [7:0] modulo_limit_reg;
    logic overflow_flag_reg;
    logic overflow_irq_enable_reg;
    logic counter_halt_reg;
    logic [1:0] source_select_reg;
    logic [3:0] prescale_select_reg;
    logic clear_armed_reg;

    logic access;
    logic capture;
    logic done;
    logic wr_en;
    logic sel_sc;
    logic sel_clk;
    logic sel_cnt;
    logic sel_mod;
    logic hit;
    logic wr_sc;
    logic rd_cap_sc;
    logic cnt_clr;
    logic flag_soft_clr;
    logic [31:0] rd_mux;

    // Bus phases: one wait cycle, then the edge that completes the access.
    assign access = psel_i & penable_i;
    assign capture = access & ~pready_reg;
    assign done = access & pready_reg;
    assign wr_en = done & pwrite_i & ~pslverr_reg;

    // Address decode.
    assign sel_sc = (paddr_i == ADDR_STATUS_CTRL);
    assign sel_clk = (paddr_i == ADDR_CLOCK_CFG);
    assign sel_cnt = (paddr_i == ADDR_COUNT);
    assign sel_mod = (paddr_i == ADDR_LIMIT);
    assign hit = sel_sc | sel_clk | sel_cnt | sel_mod;

    assign wr_sc = wr_en & sel_sc;
    assign rd_cap_sc = capture & ~pwrite_i & sel_sc;

    // A limit write or a counter-reset write clears count and flag.
    assign cnt_clr = (wr_en & sel_mod)
        | (wr_sc & pwdata_i[SC_CNT_RST_BIT]);

    // Second step of the flag clear: zero written after an armed read.
    assign flag_soft_clr = wr_sc & ~pwdata_i[SC_OVF_BIT] & clear_armed_reg;

    // Read multiplexer; reset bit and unused bits read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_sc) begin
            rd_mux[SC_OVF_BIT] = overflow_flag_reg;
            rd_mux[SC_IRQ_EN_BIT] = overflow_irq_enable_reg;
            rd_mux[SC_HALT_BIT] = counter_halt_reg;
        end else if (sel_clk) begin
            rd_mux[CLK_SRC_LSB +: 2] = source_select_reg;
            rd_mux[CLK_PS_LSB +: 4] = prescale_select_reg;
        end else if (sel_cnt) begin
            rd_mux[7:0] = count_value_reg;
        end else if (sel_mod) begin
            rd_mux[7:0] = modulo_limit_reg;
        end
    end

    // Ready, error and read data are set in the wait cycle and held one.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= capture;
            pslverr_reg <= capture & ~hit;
            if (capture & ~pwrite_i) begin
                prdata_reg <= rd_mux;
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    // Control bits of the status register.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            overflow_irq_enable_reg <= RST_IRQ_EN;
            counter_halt_reg <= RST_HALT;
        end else if (wr_sc) begin
            overflow_irq_enable_reg <= pwdata_i[SC_IRQ_EN_BIT];
            counter_halt_reg <= pwdata_i[SC_HALT_BIT];
        end
    end

    // Clock configuration; a change never touches the count.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            source_select_reg <= RST_SRC;
            prescale_select_reg <= RST_PS;
        end else if (wr_en & sel_clk) begin
            source_select_reg <= pwdata_i[CLK_SRC_LSB +: 2];
            prescale_select_reg <= pwdata_i[CLK_PS_LSB +: 4];
        end
    end

    // Limit register; every value is accepted as written.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            modulo_limit_reg <= RST_LIMIT;
        end else if (wr_en & sel_mod) begin
            modulo_limit_reg <= pwdata_i[7:0];
        end
    end

    logic fixed_rise;
    logic pin_rise;
    logic pin_fall;
    logic src_tick;
    logic cnt_tick;

    // Fixed-frequency clock is counted on its rising edges.
    mtm_edge_sync u_fixed_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .pin_i(fixed_freq_clock_i),
        .rise_o(fixed_rise),
        .fall_o()
    );

    // External pin, either edge selectable.
    mtm_edge_sync u_pin_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .pin_i(ext_count_pin_i),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    // Source multiplexer.
    always_comb begin
        case (source_select_reg)
            SRC_BUS: src_tick = 1'b1;
            SRC_FIXED: src_tick = fixed_rise;
            SRC_PIN_FALL: src_tick = pin_fall;
            SRC_PIN_RISE: src_tick = pin_rise;
            default: src_tick = 1'b1;
        endcase
    end

    // Prescaler only sees ticks while the counter runs.
    mtm_prescaler #(
        .DIV_W(8)
    ) u_prescaler (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .tick_i(src_tick & ~counter_halt_reg),
        .sel_i(prescale_select_reg),
        .tick_o(cnt_tick)
    );

    logic [7:0] wrap_at;
    logic ovf_evt;

    // A zero limit runs free over the full eight bits.
    assign wrap_at = (modulo_limit_reg == RST_LIMIT) ? FREE_RUN_TOP
        : modulo_limit_reg;

    // The wrap is lost when a clear lands in the same cycle.
    assign ovf_evt = cnt_tick & ~cnt_clr
        & (count_value_reg == wrap_at);

    // Counter: clear, wrap or increment; bus writes to it are ignored.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            count_value_reg <= RST_COUNT;
        end else if (cnt_clr) begin
            count_value_reg <= RST_COUNT;
        end else if (ovf_evt) begin
            count_value_reg <= RST_COUNT;
        end else if (cnt_tick) begin
            count_value_reg <= count_value_reg + 8'h01;
        end
    end

    // Overflow flag; a new overflow wins over the two-step clear, but a counter clear suppresses it.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag_reg <= 1'b0;
        end else if (ovf_evt) begin
            overflow_flag_reg <= 1'b1;
        end else if (cnt_clr) begin
            overflow_flag_reg <= 1'b0;
        end else if (flag_soft_clr) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    // Read step of the clear: armed by a read that shows the flag set.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clear_armed_reg <= 1'b0;
        end else if (ovf_evt | cnt_clr) begin
            clear_armed_reg <= 1'b0;
        end else if (rd_cap_sc & overflow_flag_reg) begin
            clear_armed_reg <= 1'b1;
        end else if (wr_sc) begin
            clear_armed_reg <= 1'b0;
        end
    end

    // Interrupt request follows flag and enable one cycle later.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= overflow_flag_reg & overflow_irq_enable_reg;
        end
    end

    // Outputs straight from flops.
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign irq_o = irq_reg;

    // Checks on the counter, the flag and the bus answer.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    // Armed read of a set flag followed by a clearing write.
    sequence s_armed_read;
        rd_cap_sc && overflow_flag_reg && !ovf_evt;
    endsequence

    sequence s_clear_write;
        wr_sc && !pwdata_i[SC_OVF_BIT] && !pwdata_i[SC_CNT_RST_BIT]
            && !ovf_evt;
    endsequence

    sequence s_setup;
        psel_i && !penable_i;
    endsequence

    count_ro_a: assert property (
        (wr_en && sel_cnt && !cnt_tick) |=> $stable(count_value_reg))
        else $error("count changed by a write");

    limit_clear_a: assert property (
        (wr_en && sel_mod) |=> (count_value_reg == 8'h00)
            && !overflow_flag_reg)
        else $error("limit write did not clear");

    halt_hold_a: assert property (
        (counter_halt_reg && !cnt_clr) |=> $stable(count_value_reg))
        else $error("count moved while halted");

    step_up_a: assert property (
        (cnt_tick && !cnt_clr && count_value_reg != wrap_at)
            |=> count_value_reg == $past(count_value_reg) + 8'h01)
        else $error("count did not step by one");

    wrap_flag_a: assert property (
        (cnt_tick && !cnt_clr && count_value_reg == modulo_limit_reg
            && modulo_limit_reg != 8'h00)
            |=> (count_value_reg == 8'h00) && overflow_flag_reg)
        else $error("wrap at limit missing");

    free_wrap_a: assert property (
        (modulo_limit_reg == 8'h00 && cnt_tick && !cnt_clr
            && count_value_reg == 8'hFF)
            |=> overflow_flag_reg && count_value_reg == 8'h00)
        else $error("free-run wrap missing");

    // The read step arms the clear; the armed write then drops the flag.
    arm_on_read_a: assert property (
        s_armed_read |=> clear_armed_reg)
        else $error("read of set flag did not arm");

    two_step_a: assert property (
        clear_armed_reg ##0 s_clear_write |=> !overflow_flag_reg)
        else $error("two-step clear failed");

    unarmed_keep_a: assert property (
        (overflow_flag_reg && !clear_armed_reg && wr_sc
            && !pwdata_i[SC_CNT_RST_BIT]) |=> overflow_flag_reg)
        else $error("flag cleared without a read");

    abandon_clear_a: assert property (
        (ovf_evt && clear_armed_reg)
            |=> !clear_armed_reg && overflow_flag_reg)
        else $error("clear not abandoned");

    rst_bit_a: assert property (
        (wr_sc && pwdata_i[SC_CNT_RST_BIT])
            |=> !overflow_flag_reg && count_value_reg == 8'h00)
        else $error("counter reset bit ineffective");

    irq_follow_a: assert property (
        (overflow_flag_reg && overflow_irq_enable_reg) |=> irq_reg)
        else $error("interrupt not raised");

    bus_rate_a: assert property (
        (source_select_reg == SRC_BUS && prescale_select_reg == 4'h0
            && !counter_halt_reg) |-> cnt_tick)
        else $error("bus clock not counted at divide one");

    rst_reads_zero_a: assert property (
        (pready_reg && sel_sc) |-> !prdata_reg[SC_CNT_RST_BIT])
        else $error("counter reset bit read as one");

    apb_answer_a: assert property (
        s_setup ##1 (psel_i && penable_i) |=> pready_reg ##1 !pready_reg)
        else $error("ready not one cycle after wait");

endmodule : mtm_timer
`default_nettype wire

// ==== tb/test_modulo_timer_8bit.sv ====
// Self-checking bench for the modulo timer and its register slave.
`timescale 1ns/1ps
`default_nettype none
module test_modulo_timer_8bit;
    import mtm_pkg::*;

    localparam int CEILING = 40000;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fixed_clk = 1'b0;
    logic pin = 1'b0;
    logic irq;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int fdiv = 0;

    // The timer under test.
    mtm_timer u_dut (
        .clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .fixed_freq_clock_i(fixed_clk), .ext_count_pin_i(pin), .irq_o(irq)
    );

    // The 50 MHz system clock.
    initial begin
        forever #10 clk = ~clk;
    end

    // The fixed clock runs at one tenth of the system clock.
    always @(posedge clk) begin
        if (fdiv == 4) begin
            fdiv <= 0;
            fixed_clk <= ~fixed_clk;
        end else begin
            fdiv <= fdiv + 1;
        end
    end

    // A hung run is cut short and counted as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == CEILING) begin
            miscompares++;
            $display("ERROR %0t: run took too long", $time);
            close_out();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Checks that a value lies in a window.
    task automatic in_range(input logic [31:0] v, input int lo, input int hi);
        check({31'h0, (v >= lo && v <= hi)}, 32'h00000001);
    endtask : in_range

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Register write and read helpers.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(a, 1'b1, d, rd, er);
    endtask : wr

    task automatic rv(input logic [11:0] a, output logic [31:0] d);
        logic er;
        apb(a, 1'b0, 32'h00000000, d, er);
    endtask : rv

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rv(a, d);
        check(d, exp);
    endtask : rdc

    // Reset values of all registers and the idle request line.
    task automatic t_reset;
        rdc(ADDR_STATUS_CTRL, 32'h00000010);
        rdc(ADDR_CLOCK_CFG, 32'h00000000);
        rdc(ADDR_COUNT, 32'h00000000);
        rdc(ADDR_LIMIT, 32'h00000000);
        check({31'h0, irq}, 32'h00000000);
        $display("test reset done");
    endtask : t_reset

    // Access kinds, upper bits and an unmapped address.
    task automatic t_regs;
        logic [31:0] d;
        logic er;
        wr(ADDR_LIMIT, 32'hFFFFFFFF);
        rdc(ADDR_LIMIT, 32'h000000FF);
        wr(ADDR_CLOCK_CFG, 32'h000000FF);
        rdc(ADDR_CLOCK_CFG, 32'h0000003F);
        wr(ADDR_CLOCK_CFG, 32'h00000000);
        wr(ADDR_COUNT, 32'h00000055);
        rdc(ADDR_COUNT, 32'h00000000);
        apb(12'h010, 1'b0, 32'h00000000, d, er);
        check({d[31:1], er}, 32'h00000001);
        wr(ADDR_LIMIT, 32'h00000000);
        $display("test registers done");
    endtask : t_regs

    // Modulo counting, halt, the two-step clear and a limit write.
    task automatic t_modulo;
        logic [31:0] c;
        wr(ADDR_LIMIT, 32'h00000004);
        wr(ADDR_STATUS_CTRL, 32'h00000000);
        repeat (20) @(posedge clk);
        wr(ADDR_STATUS_CTRL, 32'h00000010);
        rv(ADDR_COUNT, c);
        in_range(c, 0, 4);
        rdc(ADDR_COUNT, c);
        @(negedge clk);
        check({31'h0, irq}, 32'h00000000);
        rdc(ADDR_STATUS_CTRL, 32'h00000090);
        wr(ADDR_STATUS_CTRL, 32'h00000010);
        rdc(ADDR_STATUS_CTRL, 32'h00000010);
        wr(ADDR_STATUS_CTRL, 32'h00000000);
        repeat (12) @(posedge clk);
        wr(ADDR_STATUS_CTRL, 32'h00000010);
        rdc(ADDR_STATUS_CTRL, 32'h00000090);
        wr(ADDR_LIMIT, 32'h00000007);
        rdc(ADDR_STATUS_CTRL, 32'h00000010);
        rdc(ADDR_COUNT, 32'h00000000);
        $display("test modulo done");
    endtask : t_modulo

    // An overflow between the read and the write keeps the flag.
    task automatic t_abandon;
        wr(ADDR_LIMIT, 32'h00000001);
        wr(ADDR_STATUS_CTRL, 32'h00000000);
        repeat (10) @(posedge clk);
        rdc(ADDR_STATUS_CTRL, 32'h00000080);
        wr(ADDR_STATUS_CTRL, 32'h00000000);
        wr(ADDR_STATUS_CTRL, 32'h00000010);
        rdc(ADDR_STATUS_CTRL, 32'h00000090);
        wr(ADDR_STATUS_CTRL, 32'h00000030);
        rdc(ADDR_STATUS_CTRL, 32'h00000010);
        rdc(ADDR_COUNT, 32'h00000000);
        $display("test abandon done");
    endtask : t_abandon

    // The request follows the flag while enabled and drops on clear.
    task automatic t_irq;
        wr(ADDR_LIMIT, 32'h00000002);
        wr(ADDR_STATUS_CTRL, 32'h00000040);
        repeat (10) @(posedge clk);
        @(negedge clk);
        check({31'h0, irq}, 32'h00000001);
        wr(ADDR_STATUS_CTRL, 32'h00000050);
        rdc(ADDR_STATUS_CTRL, 32'h000000D0);
        wr(ADDR_STATUS_CTRL, 32'h00000050);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({31'h0, irq}, 32'h00000000);
        rdc(ADDR_STATUS_CTRL, 32'h00000050);
        wr(ADDR_STATUS_CTRL, 32'h00000010);
        $display("test interrupt done");
    endtask : t_irq

    // A zero limit wraps past 255 and sets the flag.
    task automatic t_free;
        logic [31:0] c;
        wr(ADDR_LIMIT, 32'h00000000);
        wr(ADDR_STATUS_CTRL, 32'h00000000);
        repeat (300) @(posedge clk);
        wr(ADDR_STATUS_CTRL, 32'h00000010);
        rdc(ADDR_STATUS_CTRL, 32'h00000090);
        rv(ADDR_COUNT, c);
        in_range(c, 42, 54);
        wr(ADDR_STATUS_CTRL, 32'h00000030);
        $display("test free run done");
    endtask : t_free

    // Prescale codes 0 to 9 and 15, so 9 and 15 are the only codes above eight that it tries.
    task automatic t_prescale;
        logic [31:0] c;
        logic [31:0] d;
        logic [3:0] code;
        int dv;
        for (int k = 0; k < 11; k++) begin
            code = (k == 10) ? 4'hF : 4'(k);
            dv = 1 << ((k > 8) ? 8 : k);
            wr(ADDR_STATUS_CTRL, 32'h00000030);
            wr(ADDR_CLOCK_CFG, {28'h0, code});
            wr(ADDR_STATUS_CTRL, 32'h00000000);
            repeat (20 * dv) @(posedge clk);
            wr(ADDR_STATUS_CTRL, 32'h00000010);
            rv(ADDR_COUNT, c);
            in_range(c, 19, 26);
        end
        wr(ADDR_STATUS_CTRL, 32'h00000030);
        wr(ADDR_CLOCK_CFG, 32'h00000008);
        wr(ADDR_STATUS_CTRL, 32'h00000000);
        repeat (600) @(posedge clk);
        rv(ADDR_COUNT, c);
        wr(ADDR_CLOCK_CFG, 32'h00000000);
        rdc(ADDR_STATUS_CTRL, 32'h00000000);
        rv(ADDR_COUNT, d);
        in_range(d - c, 1, 12);
        $display("test prescale done");
    endtask : t_prescale

    // Rate change keeps the count; pin edges and the fixed clock count.
    task automatic t_sources;
        logic [31:0] c0;
        logic [31:0] c1;
        wr(ADDR_STATUS_CTRL, 32'h00000030);
        wr(ADDR_CLOCK_CFG, 32'h00000008);
        wr(ADDR_STATUS_CTRL, 32'h00000000);
        repeat (600) @(posedge clk);
        rv(ADDR_COUNT, c0);
        wr(ADDR_CLOCK_CFG, 32'h00000000);
        rv(ADDR_COUNT, c1);
        in_range(c1 - c0, 1, 12);
        wr(ADDR_STATUS_CTRL, 32'h00000030);
        wr(ADDR_CLOCK_CFG, 32'h00000030);
        wr(ADDR_STATUS_CTRL, 32'h00000000);
        pulses(5);
        repeat (6) @(posedge clk);
        wr(ADDR_CLOCK_CFG, 32'h00000020);
        pulses(3);
        repeat (6) @(posedge clk);
        wr(ADDR_STATUS_CTRL, 32'h00000010);
        rdc(ADDR_COUNT, 32'h00000008);
        wr(ADDR_STATUS_CTRL, 32'h00000030);
        wr(ADDR_CLOCK_CFG, 32'h00000010);
        wr(ADDR_STATUS_CTRL, 32'h00000000);
        repeat (200) @(posedge clk);
        wr(ADDR_STATUS_CTRL, 32'h00000010);
        rv(ADDR_COUNT, c0);
        in_range(c0, 18, 23);
        $display("test sources done");
    endtask : t_sources

    // Pin pulses five cycles high and five low.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            pin <= 1'b1;
            repeat (5) @(posedge clk);
            pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : pulses

    // Reset, the scenarios in turn, then the verdict.
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_regs();
        t_modulo();
        t_abandon();
        t_irq();
        t_free();
        t_prescale();
        t_sources();
        close_out();
    end

endmodule : test_modulo_timer_8bit
`default_nettype wire
